/* File: pin_change_edge_interrupt.sv */
`timescale 1ns/1ps
module pin_change_edge_interrupt
  import pin_change_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic [PINS-1:0]   i_first_port_pin,
  input  wire logic [PINS-1:0]   i_second_port_pin,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_irq,
  output logic                   o_wake
);

  reg_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  logic [2*PINS-1:0] sync1_reg;
  logic [2*PINS-1:0] sync2_reg;
  logic [2*PINS-1:0] prev_reg;
  logic [2*PINS-1:0] rise_pulse;
  logic [2*PINS-1:0] fall_pulse;
  logic [2*PINS-1:0] set_pulse;

  edge_enable_t      first_en_reg;
  edge_enable_t      second_en_reg;
  logic [PINS-1:0]   first_flag_reg;
  logic [PINS-1:0]   second_flag_reg;
  logic [PINS-1:0]   first_flag_next;
  logic [PINS-1:0]   second_flag_next;
  logic              master_en_reg;
  logic              summary;
  logic [DATA_W-1:0] rdata_reg;

  // two-stage synchroniser, prev holds last synced sample
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= {i_second_port_pin, i_first_port_pin};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // prev resets low, so a pin high at reset release shows one rising edge
  assign rise_pulse = sync2_reg & ~prev_reg;
  assign fall_pulse = ~sync2_reg & prev_reg;

  genvar g;
  generate
    for (g = 0; g < 2*PINS; g++) begin : g_pin
      if (g < PINS) begin : g_first
        assign set_pulse[g] = (rise_pulse[g] & first_en_reg.rise[g])
                            | (fall_pulse[g] & first_en_reg.fall[g]);
      end else begin : g_second
        assign set_pulse[g] = (rise_pulse[g] & second_en_reg.rise[g-PINS])
                            | (fall_pulse[g] & second_en_reg.fall[g-PINS]);
      end
    end
  endgenerate

  // enable registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      first_en_reg  <= '{rise: PIN_RESET, fall: PIN_RESET};
      second_en_reg <= '{rise: PIN_RESET, fall: PIN_RESET};
    end else if (req.wr) begin
      case (req.addr)
        FIRST_PORT_RISE_ENABLE_ADDR:  first_en_reg.rise  <= req.wdata[PINS-1:0];
        FIRST_PORT_FALL_ENABLE_ADDR:  first_en_reg.fall  <= req.wdata[PINS-1:0];
        SECOND_PORT_RISE_ENABLE_ADDR: second_en_reg.rise <= req.wdata[PINS-1:0];
        SECOND_PORT_FALL_ENABLE_ADDR: second_en_reg.fall <= req.wdata[PINS-1:0];
        default: ;
      endcase
    end
  end

  // master enable; other control bits are not this block's
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      master_en_reg <= 1'b0;
    end else if (req.wr && req.addr == INTERRUPT_CONTROL_ADDR) begin
      master_en_reg <= req.wdata[MASTER_ENABLE_BIT];
    end
  end

  // written value ANDed into the flags first, then set pulses OR on top so the edge wins
  always_comb begin
    first_flag_next  = first_flag_reg;
    second_flag_next = second_flag_reg;
    if (req.wr && req.addr == FIRST_PORT_CHANGE_FLAGS_ADDR) begin
      first_flag_next = first_flag_reg & req.wdata[PINS-1:0];
    end
    if (req.wr && req.addr == SECOND_PORT_CHANGE_FLAGS_ADDR) begin
      second_flag_next = second_flag_reg & req.wdata[PINS-1:0];
    end
    first_flag_next  = first_flag_next | set_pulse[PINS-1:0];
    second_flag_next = second_flag_next | set_pulse[2*PINS-1:PINS];
  end

  // flags are sticky; clock runs in sleep so flags are current on wake
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      first_flag_reg  <= PIN_RESET;
      second_flag_reg <= PIN_RESET;
    end else begin
      first_flag_reg  <= first_flag_next;
      second_flag_reg <= second_flag_next;
    end
  end

  assign summary = |{first_flag_reg, second_flag_reg};

  // wake and request share one gate; the flag reg is set in the same edge
  assign o_irq  = summary & master_en_reg;
  assign o_wake = summary & master_en_reg;

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_reg <= READ_ZERO;
    end else begin
      rdata_reg <= READ_ZERO;
      if (req.rd) begin
        case (req.addr)
          FIRST_PORT_RISE_ENABLE_ADDR:   rdata_reg <= {2'h0, first_en_reg.rise};
          FIRST_PORT_FALL_ENABLE_ADDR:   rdata_reg <= {2'h0, first_en_reg.fall};
          FIRST_PORT_CHANGE_FLAGS_ADDR:  rdata_reg <= {2'h0, first_flag_reg};
          SECOND_PORT_RISE_ENABLE_ADDR:  rdata_reg <= {2'h0, second_en_reg.rise};
          SECOND_PORT_FALL_ENABLE_ADDR:  rdata_reg <= {2'h0, second_en_reg.fall};
          SECOND_PORT_CHANGE_FLAGS_ADDR: rdata_reg <= {2'h0, second_flag_reg};
          INTERRUPT_CONTROL_ADDR: begin
            rdata_reg                    <= READ_ZERO;
            rdata_reg[MASTER_ENABLE_BIT] <= master_en_reg;
            rdata_reg[SUMMARY_FLAG_BIT]  <= summary;
          end
          default: rdata_reg <= READ_ZERO;
        endcase
      end
    end
  end

  assign o_rdata = rdata_reg;

endmodule : pin_change_edge_interrupt

/* File: pin_change_edge_interrupt_sva.sv */
`timescale 1ns/1ps
module pin_change_edge_interrupt_sva
  import pin_change_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_irq,
  input wire logic              o_wake
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_wake_follow: assert property (o_wake == o_irq)
    else $error("wake differs");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  chk_upper_zero: assert property ($past(i_rd) && $past(i_addr) < 4'h6 |-> o_rdata[7:6] == 2'h0)
    else $error("upper bits set");
  chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 4'h6 |-> o_rdata == 8'h00)
    else $error("unmapped read");
  chk_ctrl_read: assert property ($past(i_rd) && $past(i_addr) == 4'h6 |->
    (o_rdata[3] & o_rdata[0]) == $past(o_irq) && (o_rdata & 8'hF6) == 8'h00)
    else $error("control read");
  chk_irq_sticky: assert property (o_irq && !i_wr |=> o_irq)
    else $error("irq dropped");
  chk_reset_clear: assert property ($fell(i_rst) |-> !o_irq && o_rdata == 8'h00)
    else $error("not clear after reset");
  chk_drop_cause: assert property ($fell(o_irq) && !$past(i_rst) |-> $past(i_wr))
    else $error("irq fell without write");
endmodule : pin_change_edge_interrupt_sva
bind pin_change_edge_interrupt pin_change_edge_interrupt_sva chk_u (.i_core_clk, .i_rst,
  .i_addr, .i_wr, .i_rd, .o_rdata, .o_irq, .o_wake);

/* File: pin_change_edge_interrupt_test.sv */
`timescale 1ns/1ps
module pin_change_edge_interrupt_test;
  import pin_change_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, irq, wake;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00, rdata;
  logic [PIN_COUNT-1:0] lvl_a = 6'h00, lvl_b = 6'h00, pin_a, pin_b;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #2 clk = ~clk;
  pin_source_model src_u (.i_first_level(lvl_a), .i_second_level(lvl_b),
    .o_first_port_pin(pin_a), .o_second_port_pin(pin_b));
  pin_change_edge_interrupt dut_u (.i_core_clk(clk), .i_rst(rst), .i_first_port_pin(pin_a),
    .i_second_port_pin(pin_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq(irq), .o_wake(wake));
  task check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rd_reg
  task set_pins(input logic [5:0] a, input logic [5:0] b, input int n);
    @(posedge clk);
    lvl_a <= a;
    lvl_b <= b;
    repeat (n) @(posedge clk);
  endtask : set_pins
  task irq_is(input logic exp);
    @(negedge clk);
    check({7'h00, irq}, {7'h00, exp});
    check({7'h00, wake}, {7'h00, exp});
  endtask : irq_is
  task final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd_reg(a[3:0], 8'h00);
    wr_reg(4'h0, 8'hFF);
    rd_reg(4'h0, 8'h3F);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00);
    wr_reg(4'h6, 8'hF7);
    rd_reg(4'h6, 8'h00);
    wr_reg(4'h0, 8'h05);
    wr_reg(4'h1, 8'h06);
    wr_reg(4'h3, 8'h3F);
    wr_reg(4'h4, 8'h01);
    set_pins(6'h07, 6'h00, 5);
    rd_reg(4'h2, 8'h05);
    irq_is(1'b0);
    rd_reg(4'h6, 8'h01);
    set_pins(6'h00, 6'h00, 5);
    rd_reg(4'h2, 8'h07);
    wr_reg(4'h6, 8'h08);
    irq_is(1'b1);
    wr_reg(4'h2, 8'hF8);
    rd_reg(4'h2, 8'h00);
    irq_is(1'b0);
    set_pins(6'h00, 6'h3F, 5);
    rd_reg(4'h5, 8'h3F);
    set_pins(6'h00, 6'h3E, 1);
    wr_reg(4'h5, 8'hC0);
    rd_reg(4'h5, 8'h01);
    wr_reg(4'h6, 8'h00);
    irq_is(1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h4, 8'h00);
    rd_reg(4'h5, 8'h00);
    final_report();
  end
endmodule : pin_change_edge_interrupt_test

/* File: pin_change_pkg.sv */
package pin_change_pkg;

  localparam int PIN_COUNT = 6;
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 8;

  localparam logic [ADDR_W-1:0] FIRST_PORT_RISE_ENABLE_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] FIRST_PORT_FALL_ENABLE_ADDR   = 4'h1;
  localparam logic [ADDR_W-1:0] FIRST_PORT_CHANGE_FLAGS_ADDR  = 4'h2;
  localparam logic [ADDR_W-1:0] SECOND_PORT_RISE_ENABLE_ADDR  = 4'h3;
  localparam logic [ADDR_W-1:0] SECOND_PORT_FALL_ENABLE_ADDR  = 4'h4;
  localparam logic [ADDR_W-1:0] SECOND_PORT_CHANGE_FLAGS_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_ADDR        = 4'h6;

  localparam int MASTER_ENABLE_BIT = 3;
  localparam int SUMMARY_FLAG_BIT  = 0;

  localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h00;
  localparam logic [DATA_W-1:0]    READ_ZERO = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
  } edge_enable_t;

endpackage : pin_change_pkg

/* File: pin_source_model.sv */
`timescale 1ns/1ps
module pin_source_model
  import pin_change_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] i_first_level,
  input  wire logic [PIN_COUNT-1:0] i_second_level,
  output logic      [PIN_COUNT-1:0] o_first_port_pin,
  output logic      [PIN_COUNT-1:0] o_second_port_pin
);
  // driven levels, held a full cycle or more so no edge is missed
  assign o_first_port_pin  = i_first_level;
  assign o_second_port_pin = i_second_level;
endmodule : pin_source_model
